// ---- rtl/drp_regs_top.v ----
// Purpose: Third reference profile and fourth reference priority registers of the first digital PLL
// Assumes: One clock, synchronous active-low reset, simple strobe register port
// Notes:   Settings reach the loop only while the third reference is selected
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "drp_consts.vh"

module drp_regs_top
(
  input  wire        CLOCK,
  input  wire        NRST,
  input  wire [15:0] ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output wire [7:0]  RDATA,
  input  wire        REF1_EN,
  input  wire [1:0]  REF1_PRIO,
  input  wire        REF2_EN,
  input  wire [1:0]  REF2_PRIO,
  output wire        REF3_EN,
  output wire [1:0]  REF3_PRIO,
  output wire        REF4_EN,
  output wire [1:0]  REF4_PRIO,
  output wire        SEL_VALID,
  output wire [1:0]  SEL_IDX,
  output wire        REF3_IN_USE,
  output wire [16:0] APPLIED_BW_SCALE,
  output wire        APPLIED_HIGH_MARGIN,
  output wire [18:0] APPLIED_FB_DIVIDE,
  output wire [23:0] APPLIED_FRAC_NUM,
  output wire [23:0] APPLIED_FRAC_MOD
);

  reg  [7:0]  ref3_select_priority_reg;
  reg  [7:0]  ref3_bw_scale_low_reg;
  reg  [7:0]  ref3_bw_scale_mid_reg;
  reg  [7:0]  ref3_bw_top_filter_sel_reg;
  reg  [7:0]  ref3_int_div_low_reg;
  reg  [7:0]  ref3_int_div_mid_reg;
  reg  [7:0]  ref3_int_div_top_reg;
  reg  [7:0]  ref3_frac_num_low_reg;
  reg  [7:0]  ref3_frac_num_mid_reg;
  reg  [7:0]  ref3_frac_num_top_reg;
  reg  [7:0]  ref3_frac_modulus_low_reg;
  reg  [7:0]  ref3_frac_modulus_mid_reg;
  reg  [7:0]  ref3_frac_modulus_top_reg;
  reg  [7:0]  ref4_select_priority_reg;
  reg  [7:0]  rdata_reg;
  reg  [7:0]  rdata_next;
  reg         in_use_reg;
  reg  [16:0] applied_bw_reg;
  reg         applied_margin_reg;
  reg  [18:0] applied_div_reg;
  reg  [23:0] applied_num_reg;
  reg  [23:0] applied_mod_reg;
  wire [16:0] ref3_bw_scale;
  wire        ref3_high_margin;
  wire [17:0] ref3_div_minus_one;
  wire [23:0] ref3_frac_num;
  wire [23:0] ref3_frac_mod;
  wire [3:0]  sel_en;
  wire [7:0]  sel_pri;
  wire        sel_valid;
  wire [1:0]  sel_idx;
  wire        ref3_selected;

  // Register writes; bits that hold nothing are dropped so they read zero
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      ref3_select_priority_reg   <= `DRP_RST_BYTE;
      ref3_bw_scale_low_reg      <= `DRP_RST_BYTE;
      ref3_bw_scale_mid_reg      <= `DRP_RST_BYTE;
      ref3_bw_top_filter_sel_reg <= `DRP_RST_BYTE;
      ref3_int_div_low_reg       <= `DRP_RST_BYTE;
      ref3_int_div_mid_reg       <= `DRP_RST_BYTE;
      ref3_int_div_top_reg       <= `DRP_RST_BYTE;
      ref3_frac_num_low_reg      <= `DRP_RST_BYTE;
      ref3_frac_num_mid_reg      <= `DRP_RST_BYTE;
      ref3_frac_num_top_reg      <= `DRP_RST_BYTE;
      ref3_frac_modulus_low_reg  <= `DRP_RST_BYTE;
      ref3_frac_modulus_mid_reg  <= `DRP_RST_BYTE;
      ref3_frac_modulus_top_reg  <= `DRP_RST_BYTE;
      ref4_select_priority_reg   <= `DRP_RST_BYTE;
    end
    else if (WR)
    begin
      case (ADDR)
        `DRP_OFS_REF3_PRIO:
        begin
          ref3_select_priority_reg <= WDATA & `DRP_PRIO_USED_MASK;
        end
        `DRP_OFS_REF3_BW_LOW:
        begin
          ref3_bw_scale_low_reg <= WDATA;
        end
        `DRP_OFS_REF3_BW_MID:
        begin
          ref3_bw_scale_mid_reg <= WDATA;
        end
        `DRP_OFS_REF3_BW_TOP:
        begin
          ref3_bw_top_filter_sel_reg <= WDATA & `DRP_BW_TOP_MASK;
        end
        `DRP_OFS_REF3_DIV_LOW:
        begin
          ref3_int_div_low_reg <= WDATA;
        end
        `DRP_OFS_REF3_DIV_MID:
        begin
          ref3_int_div_mid_reg <= WDATA;
        end
        `DRP_OFS_REF3_DIV_TOP:
        begin
          ref3_int_div_top_reg <= WDATA & `DRP_DIV_TOP_MASK;
        end
        `DRP_OFS_REF3_NUM_LOW:
        begin
          ref3_frac_num_low_reg <= WDATA;
        end
        `DRP_OFS_REF3_NUM_MID:
        begin
          ref3_frac_num_mid_reg <= WDATA;
        end
        `DRP_OFS_REF3_NUM_TOP:
        begin
          ref3_frac_num_top_reg <= WDATA;
        end
        `DRP_OFS_REF3_MOD_LOW:
        begin
          ref3_frac_modulus_low_reg <= WDATA;
        end
        `DRP_OFS_REF3_MOD_MID:
        begin
          ref3_frac_modulus_mid_reg <= WDATA;
        end
        `DRP_OFS_REF3_MOD_TOP:
        begin
          ref3_frac_modulus_top_reg <= WDATA;
        end
        `DRP_OFS_REF4_PRIO:
        begin
          ref4_select_priority_reg <= WDATA & `DRP_PRIO_USED_MASK;
        end
        default:
        begin
          ref4_select_priority_reg <= ref4_select_priority_reg;
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rdata_next = `DRP_RST_BYTE;
    case (ADDR)
      `DRP_OFS_REF3_PRIO:
      begin
        rdata_next = ref3_select_priority_reg;
      end
      `DRP_OFS_REF3_BW_LOW:
      begin
        rdata_next = ref3_bw_scale_low_reg;
      end
      `DRP_OFS_REF3_BW_MID:
      begin
        rdata_next = ref3_bw_scale_mid_reg;
      end
      `DRP_OFS_REF3_BW_TOP:
      begin
        rdata_next = ref3_bw_top_filter_sel_reg;
      end
      `DRP_OFS_REF3_DIV_LOW:
      begin
        rdata_next = ref3_int_div_low_reg;
      end
      `DRP_OFS_REF3_DIV_MID:
      begin
        rdata_next = ref3_int_div_mid_reg;
      end
      `DRP_OFS_REF3_DIV_TOP:
      begin
        rdata_next = ref3_int_div_top_reg;
      end
      `DRP_OFS_REF3_NUM_LOW:
      begin
        rdata_next = ref3_frac_num_low_reg;
      end
      `DRP_OFS_REF3_NUM_MID:
      begin
        rdata_next = ref3_frac_num_mid_reg;
      end
      `DRP_OFS_REF3_NUM_TOP:
      begin
        rdata_next = ref3_frac_num_top_reg;
      end
      `DRP_OFS_REF3_MOD_LOW:
      begin
        rdata_next = ref3_frac_modulus_low_reg;
      end
      `DRP_OFS_REF3_MOD_MID:
      begin
        rdata_next = ref3_frac_modulus_mid_reg;
      end
      `DRP_OFS_REF3_MOD_TOP:
      begin
        rdata_next = ref3_frac_modulus_top_reg;
      end
      `DRP_OFS_REF4_PRIO:
      begin
        rdata_next = ref4_select_priority_reg;
      end
      `DRP_OFS_SEL_STATUS:
      begin
        rdata_next = {4'h0, in_use_reg, sel_valid, sel_idx};
      end
      default:
      begin
        rdata_next = `DRP_RST_BYTE;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      rdata_reg <= `DRP_RST_BYTE;
    end
    else if (RD)
    begin
      rdata_reg <= rdata_next;
    end
    else
    begin
      rdata_reg <= `DRP_RST_BYTE;
    end
  end

  // Multi-byte fields assembled low byte first
  assign ref3_bw_scale      = {ref3_bw_top_filter_sel_reg[`DRP_BW_TOP_BIT],
                               ref3_bw_scale_mid_reg, ref3_bw_scale_low_reg};
  assign ref3_high_margin   = ref3_bw_top_filter_sel_reg[`DRP_FILTER_SEL_BIT];
  assign ref3_div_minus_one = {ref3_int_div_top_reg[1:0],
                               ref3_int_div_mid_reg, ref3_int_div_low_reg};
  assign ref3_frac_num      = {ref3_frac_num_top_reg, ref3_frac_num_mid_reg,
                               ref3_frac_num_low_reg};
  assign ref3_frac_mod      = {ref3_frac_modulus_top_reg, ref3_frac_modulus_mid_reg,
                               ref3_frac_modulus_low_reg};

  assign sel_en  = {ref4_select_priority_reg[`DRP_PRIO_EN_BIT],
                    ref3_select_priority_reg[`DRP_PRIO_EN_BIT],
                    REF2_EN, REF1_EN};
  assign sel_pri = {ref4_select_priority_reg[`DRP_PRIO_MSB:`DRP_PRIO_LSB],
                    ref3_select_priority_reg[`DRP_PRIO_MSB:`DRP_PRIO_LSB],
                    REF2_PRIO, REF1_PRIO};

  drp_ref_select u_select
  (
    .clock     (CLOCK),
    .nrst      (NRST),
    .ref_en    (sel_en),
    .ref_pri   (sel_pri),
    .sel_valid (sel_valid),
    .sel_idx   (sel_idx)
  );

  assign ref3_selected = sel_valid && (sel_idx == `DRP_REF3_INDEX);

  // Loop settings follow the profile only while the third reference is selected
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      in_use_reg         <= 1'b0;
      applied_bw_reg     <= 17'h00000;
      applied_margin_reg <= 1'b0;
      applied_div_reg    <= 19'h00000;
      applied_num_reg    <= 24'h000000;
      applied_mod_reg    <= 24'h000000;
    end
    else if (ref3_selected)
    begin
      in_use_reg         <= 1'b1;
      applied_bw_reg     <= ref3_bw_scale;
      applied_margin_reg <= ref3_high_margin;
      applied_div_reg    <= {1'b0, ref3_div_minus_one} + 19'h00001;
      applied_num_reg    <= ref3_frac_num;
      applied_mod_reg    <= ref3_frac_mod;
    end
    else
    begin
      in_use_reg         <= 1'b0;
      applied_bw_reg     <= 17'h00000;
      applied_margin_reg <= 1'b0;
      applied_div_reg    <= 19'h00000;
      applied_num_reg    <= 24'h000000;
      applied_mod_reg    <= 24'h000000;
    end
  end

  assign RDATA               = rdata_reg;
  assign REF3_EN             = ref3_select_priority_reg[`DRP_PRIO_EN_BIT];
  assign REF3_PRIO           = ref3_select_priority_reg[`DRP_PRIO_MSB:`DRP_PRIO_LSB];
  assign REF4_EN             = ref4_select_priority_reg[`DRP_PRIO_EN_BIT];
  assign REF4_PRIO           = ref4_select_priority_reg[`DRP_PRIO_MSB:`DRP_PRIO_LSB];
  assign SEL_VALID           = sel_valid;
  assign SEL_IDX             = sel_idx;
  assign REF3_IN_USE         = in_use_reg;
  assign APPLIED_BW_SCALE    = applied_bw_reg;
  assign APPLIED_HIGH_MARGIN = applied_margin_reg;
  assign APPLIED_FB_DIVIDE   = applied_div_reg;
  assign APPLIED_FRAC_NUM    = applied_num_reg;
  assign APPLIED_FRAC_MOD    = applied_mod_reg;

endmodule

// ---- rtl/drp_consts.vh ----
// Purpose: Constants for the reference profile register bank
// Assumes: Byte-wide registers at byte addresses on a 16-bit address port
// Notes:   Offsets, field positions, reset values and reference indices
`ifndef DRP_CONSTS_VH
`define DRP_CONSTS_VH

`define DRP_ADDR_W            16
`define DRP_DATA_W            8

`define DRP_OFS_REF3_PRIO     16'h045A
`define DRP_OFS_REF3_BW_LOW   16'h045B
`define DRP_OFS_REF3_BW_MID   16'h045C
`define DRP_OFS_REF3_BW_TOP   16'h045D
`define DRP_OFS_REF3_DIV_LOW  16'h045E
`define DRP_OFS_REF3_DIV_MID  16'h045F
`define DRP_OFS_REF3_DIV_TOP  16'h0460
`define DRP_OFS_REF3_NUM_LOW  16'h0461
`define DRP_OFS_REF3_NUM_MID  16'h0462
`define DRP_OFS_REF3_NUM_TOP  16'h0463
`define DRP_OFS_REF3_MOD_LOW  16'h0464
`define DRP_OFS_REF3_MOD_MID  16'h0465
`define DRP_OFS_REF3_MOD_TOP  16'h0466
`define DRP_OFS_REF4_PRIO     16'h0467
`define DRP_OFS_SEL_STATUS    16'h04F0

`define DRP_PRIO_EN_BIT       0
`define DRP_PRIO_LSB          1
`define DRP_PRIO_MSB          2
`define DRP_PRIO_USED_MASK    8'h07
`define DRP_FILTER_SEL_BIT    1
`define DRP_BW_TOP_BIT        0
`define DRP_BW_TOP_MASK       8'h03
`define DRP_DIV_TOP_MASK      8'h03

`define DRP_RST_BYTE          8'h00
`define DRP_RST_PRIO          2'h0

`define DRP_REF_COUNT         4
`define DRP_REF3_INDEX        2'h2
`define DRP_REF4_INDEX        2'h3

`endif

// ---- rtl/drp_ref_select.v ----
// Purpose: Picks the reference that the first digital PLL should use
// Assumes: Enables and priorities come from logic on the same clock
// Notes:   Lowest priority number wins; a tie goes to the lower index
`timescale 1ns/1ps
`include "drp_consts.vh"

module drp_ref_select
(
  input  wire       clock,
  input  wire       nrst,
  input  wire [3:0] ref_en,
  input  wire [7:0] ref_pri,
  output wire       sel_valid,
  output wire [1:0] sel_idx
);

  reg       sel_valid_reg;
  reg [1:0] sel_idx_reg;
  reg       sel_valid_next;
  reg [1:0] sel_idx_next;
  reg [1:0] best_pri;
  integer   i;

  // Walk from the top index down so an equal priority lets the lower index win
  always @*
  begin
    sel_valid_next = 1'b0;
    sel_idx_next   = 2'h0;
    best_pri       = 2'h3;
    for (i = `DRP_REF_COUNT - 1; i >= 0; i = i - 1)
    begin
      if (ref_en[i] && (!sel_valid_next || ref_pri[2*i +: 2] <= best_pri))
      begin
        sel_valid_next = 1'b1;
        sel_idx_next   = i[1:0];
        best_pri       = ref_pri[2*i +: 2];
      end
    end
  end

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      sel_valid_reg <= 1'b0;
      sel_idx_reg   <= 2'h0;
    end
    else
    begin
      sel_valid_reg <= sel_valid_next;
      sel_idx_reg   <= sel_idx_next;
    end
  end

  assign sel_valid = sel_valid_reg;
  assign sel_idx   = sel_idx_reg;

endmodule

// ---- tb/drp_regs_asserts.sv ----
// Purpose: Port checks for the reference profile register bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module from the bench file
`timescale 1ns/1ps
module drp_regs_asserts
(
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic [15:0] ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic        REF3_EN,
  input wire logic [1:0]  REF3_PRIO,
  input wire logic        REF4_EN,
  input wire logic [1:0]  REF4_PRIO,
  input wire logic        SEL_VALID,
  input wire logic [1:0]  SEL_IDX,
  input wire logic        REF3_IN_USE,
  input wire logic [16:0] APPLIED_BW_SCALE,
  input wire logic        APPLIED_HIGH_MARGIN,
  input wire logic [18:0] APPLIED_FB_DIVIDE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  property p_ref3_wr;
    WR && ADDR == 16'h045A |=> REF3_EN == $past(WDATA[0]) && REF3_PRIO == $past(WDATA[2:1]);
  endproperty
  a_ref3_wr: assert property (p_ref3_wr) else $error("third priority byte not taken");

  property p_ref4_wr;
    WR && ADDR == 16'h0467 |=> REF4_EN == $past(WDATA[0]) && REF4_PRIO == $past(WDATA[2:1]);
  endproperty
  a_ref4_wr: assert property (p_ref4_wr) else $error("fourth priority byte not taken");

  property p_prio_rd;
    RD && ADDR == 16'h045A |=> RDATA == {5'h00, $past(REF3_PRIO), $past(REF3_EN)};
  endproperty
  a_prio_rd: assert property (p_prio_rd) else $error("priority readback wrong");

  property p_sel_enabled;
    SEL_VALID && SEL_IDX == 2'h2 |-> $past(REF3_EN);
  endproperty
  a_sel_enabled: assert property (p_sel_enabled) else $error("disabled reference selected");

  property p_in_use;
    1'b1 |-> REF3_IN_USE == $past(SEL_VALID && SEL_IDX == 2'h2);
  endproperty
  a_in_use: assert property (p_in_use) else $error("in-use flag not following selection");

  property p_applied_zero;
    !REF3_IN_USE |-> APPLIED_BW_SCALE == 17'h00000 && !APPLIED_HIGH_MARGIN && APPLIED_FB_DIVIDE == 19'h00000;
  endproperty
  a_applied_zero: assert property (p_applied_zero) else $error("settings applied while unselected");

  property p_div_plus1;
    REF3_IN_USE |-> APPLIED_FB_DIVIDE != 19'h00000;
  endproperty
  a_div_plus1: assert property (p_div_plus1) else $error("divide value not stored plus one");

  property p_prio_pick;
    SEL_VALID && SEL_IDX == 2'h3 && $past(REF3_EN) |-> $past(REF4_PRIO) < $past(REF3_PRIO);
  endproperty
  a_prio_pick: assert property (p_prio_pick) else $error("priority order broken");
endmodule

// ---- tb/drp_regs_top_bench.sv ----
// Purpose: Self-checking bench for the reference profile register bank
// Assumes: Strobe register port, read data one cycle after the read strobe
// Notes:   Selection results settle three edges after a write
`timescale 1ns/1ps
`include "drp_consts.vh"
module drp_regs_top_bench;
  logic        CLOCK = 1'b0;
  logic        NRST = 1'b0;
  logic [15:0] ADDR = 16'h0000;
  logic [7:0]  WDATA = 8'h00;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        REF1_EN = 1'b0;
  logic [1:0]  REF1_PRIO = 2'h0;
  logic        REF2_EN = 1'b0;
  logic [1:0]  REF2_PRIO = 2'h0;
  wire  [7:0]  RDATA;
  wire         REF3_EN, REF4_EN, SEL_VALID, REF3_IN_USE, APPLIED_HIGH_MARGIN;
  wire  [1:0]  REF3_PRIO, REF4_PRIO, SEL_IDX;
  wire  [16:0] APPLIED_BW_SCALE;
  wire  [18:0] APPLIED_FB_DIVIDE;
  wire  [23:0] APPLIED_FRAC_NUM, APPLIED_FRAC_MOD;
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [7:0]  wv [12] = '{8'h34, 8'h12, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h02, 8'h83, 8'hA5, 8'h5A, 8'hC3};

  drp_regs_top u_drp_regs_top (.CLOCK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .REF1_EN, .REF1_PRIO,
    .REF2_EN, .REF2_PRIO, .REF3_EN, .REF3_PRIO, .REF4_EN, .REF4_PRIO, .SEL_VALID, .SEL_IDX, .REF3_IN_USE,
    .APPLIED_BW_SCALE, .APPLIED_HIGH_MARGIN, .APPLIED_FB_DIVIDE, .APPLIED_FRAC_NUM, .APPLIED_FRAC_MOD);

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    WR <= 1'b1;
    RD <= 1'b0;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    WR <= 1'b0;
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    cmp({16'h0000, RDATA}, {16'h0000, e});
    @(posedge CLOCK);
  endtask

  task automatic tick(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  // Selection pair, then every applied setting
  task automatic app(input logic [2:0] sel, input logic [16:0] bw, input logic hm, input logic [18:0] dv,
    input logic [23:0] num, input logic [23:0] md);
    cmp({21'h0, SEL_VALID, SEL_IDX}, {21'h0, sel});
    cmp({5'h00, REF3_IN_USE, APPLIED_HIGH_MARGIN, APPLIED_BW_SCALE}, {5'h00, sel == 3'h6, hm, bw});
    cmp({5'h00, APPLIED_FB_DIVIDE}, {5'h00, dv});
    cmp(APPLIED_FRAC_NUM, num);
    cmp(APPLIED_FRAC_MOD, md);
  endtask

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    forever #4 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      $display("Error at %0t: timeout", $time);
      conclude;
    end
  end

  initial
  begin
    repeat (16) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    for (int i = 0; i < 14; i++)
      rd(`DRP_OFS_REF3_PRIO + 16'(i), 8'h00);
    rd(`DRP_OFS_SEL_STATUS, 8'h00);
    rd(16'h0474, 8'h00);
    app(3'h0, 17'h00000, 1'b0, 19'h00000, 24'h0, 24'h0);
    $display("test reset done");
    wr(`DRP_OFS_REF3_PRIO, 8'hFF);
    rd(`DRP_OFS_REF3_PRIO, 8'h07);
    for (int p = 0; p < 4; p++)
    begin
      wr(`DRP_OFS_REF3_PRIO, {5'h00, 2'(p), 1'b1});
      tick(1);
      cmp({21'h0, REF3_PRIO, REF3_EN}, {21'h0, 2'(p), 1'b1});
    end
    wr(`DRP_OFS_REF4_PRIO, 8'hFD);
    tick(1);
    cmp({21'h0, REF4_PRIO, REF4_EN}, 24'h000005);
    rd(`DRP_OFS_REF4_PRIO, 8'h05);
    wr(`DRP_OFS_REF3_PRIO, 8'h00);
    wr(`DRP_OFS_REF4_PRIO, 8'h00);
    $display("test priority done");
    // Nonzero bandwidth well above 50 Hz
    for (int i = 0; i < 12; i++)
      wr(`DRP_OFS_REF3_BW_LOW + 16'(i), wv[i]);
    for (int i = 0; i < 12; i++)
      rd(`DRP_OFS_REF3_BW_LOW + 16'(i), (i == 2 || i == 5) ? 8'h03 : wv[i]);
    $display("test profile done");
    wr(`DRP_OFS_REF3_PRIO, 8'h01);
    tick(3);
    app(3'h6, 17'h11234, 1'b1, 19'h40000, 24'h830201, 24'hC35AA5);
    rd(`DRP_OFS_SEL_STATUS, 8'h0E);
    REF1_EN <= 1'b1;
    tick(3);
    app(3'h4, 17'h00000, 1'b0, 19'h00000, 24'h0, 24'h0);
    REF1_PRIO <= 2'h1;
    REF2_EN <= 1'b1;
    REF2_PRIO <= 2'h3;
    wr(`DRP_OFS_REF4_PRIO, 8'h01);
    tick(3);
    app(3'h6, 17'h11234, 1'b1, 19'h40000, 24'h830201, 24'hC35AA5);
    wr(`DRP_OFS_REF3_PRIO, 8'h05);
    tick(3);
    app(3'h7, 17'h00000, 1'b0, 19'h00000, 24'h0, 24'h0);
    REF1_EN <= 1'b0;
    wr(`DRP_OFS_REF4_PRIO, 8'h00);
    wr(`DRP_OFS_REF3_BW_TOP, 8'h01);
    tick(3);
    app(3'h6, 17'h11234, 1'b0, 19'h40000, 24'h830201, 24'hC35AA5);
    wr(`DRP_OFS_REF3_PRIO, 8'h04);
    tick(3);
    app(3'h5, 17'h00000, 1'b0, 19'h00000, 24'h0, 24'h0);
    $display("test selection done");
    // Reset in mid-run must clear every written byte again
    @(posedge CLOCK);
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    wr(`DRP_OFS_SEL_STATUS, 8'hFF);
    for (int i = 0; i < 14; i++)
      rd(`DRP_OFS_REF3_PRIO + 16'(i), 8'h00);
    rd(`DRP_OFS_SEL_STATUS, 8'h05);
    tick(1);
    app(3'h5, 17'h00000, 1'b0, 19'h00000, 24'h0, 24'h0);
    $display("test mid-run reset done");
    conclude;
  end
endmodule

bind drp_regs_top drp_regs_asserts u_drp_regs_asserts (.CLOCK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .REF3_EN, .REF3_PRIO, .REF4_EN, .REF4_PRIO, .SEL_VALID, .SEL_IDX, .REF3_IN_USE, .APPLIED_BW_SCALE,
  .APPLIED_HIGH_MARGIN, .APPLIED_FB_DIVIDE);
